// File: verilog/fzdc_pkg.sv
// Constants, register map and reset values of the fan zone duty controller.
// Assumes a 50 MHz APB clock and 8-bit temperature readings in whole degrees C.
package fzdc_pkg;
    localparam int         CLK_HZ          = 50_000_000;
    localparam int         TICK_PERIOD_MS  = 1000;
    localparam int         TICK_CYCLES     = CLK_HZ / 1000 * TICK_PERIOD_MS;
    localparam int         NUM_ZONES       = 3;
    localparam int         NUM_FANS        = 5;
    // Byte offsets on the register bus.
    localparam logic [7:0] OFS_CTRL        = 8'h00;
    localparam logic [7:0] OFS_STATUS      = 8'h04;
    localparam logic [7:0] OFS_ZONE_BASE   = 8'h08;
    localparam logic [7:0] OFS_ZONE_END    = 8'h1C;
    // Field positions.
    localparam int         POS_FLOOR       = 0;
    localparam int         POS_CEIL        = 8;
    localparam int         POS_FORCE       = 16;
    localparam int         POS_UP_TEMP     = 0;
    localparam int         POS_DOWN_TEMP   = 8;
    localparam int         POS_HYST        = 16;
    localparam int         POS_UP_IVL      = 0;
    localparam int         POS_UP_STEP     = 8;
    localparam int         POS_DOWN_IVL    = 16;
    localparam int         POS_DOWN_STEP   = 24;
    localparam int         POS_ST_FORCED   = 24;
    localparam int         POS_ST_FAIL     = 25;
    localparam int         POS_ST_UPDATE   = 26;
    // Reset values and full duty, duty in percent and temperatures in degrees C.
    localparam logic [6:0] RST_FLOOR       = 7'h0F;
    localparam logic [6:0] RST_CEIL        = 7'h5F;
    localparam logic [6:0] DUTY_FULL       = 7'h64;
    localparam logic [7:0] RST_IVL         = 8'h01;
    localparam logic [7:0] RST_STEP        = 8'h01;
    localparam logic [7:0] RST_HYST        = 8'h00;
    localparam logic [7:0] RST_UP_TEMP   [NUM_ZONES] = '{8'h50, 8'h46, 8'h3C};
    localparam logic [7:0] RST_DOWN_TEMP [NUM_ZONES] = '{8'h41, 8'h3C, 8'h32};
endpackage : fzdc_pkg

// File: verilog/fzdc_zone.sv
// One cooling zone: closed-loop duty ramp driven by the one-second tick.
// Assumes tick is a single-cycle pulse and config fields are stable levels.
`timescale 1ns/1ns
module fzdc_zone
    import fzdc_pkg::*;
(
    // Clock, reset and tick.
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       tick,
    // Zone reading.
    input  wire logic [7:0] temp,
    input  wire logic       temp_valid,
    // Settings.
    input  wire logic [7:0] up_temp,
    input  wire logic [7:0] down_temp,
    input  wire logic [7:0] hyst,
    input  wire logic [7:0] up_ivl,
    input  wire logic [7:0] up_step,
    input  wire logic [7:0] down_ivl,
    input  wire logic [7:0] down_step,
    input  wire logic [6:0] floor_duty,
    input  wire logic [6:0] ceil_duty,
    // Result.
    output logic      [6:0] duty
);
    logic [7:0] sec_cnt;
    logic [7:0] next_sec_cnt;
    logic [6:0] next_duty;
    wire        hot     = temp_valid && (temp >= up_temp);
    wire        cold    = temp_valid && (({1'b0, temp} + {1'b0, hyst}) < {1'b0, down_temp});
    wire  [7:0] ivl     = hot ? up_ivl : down_ivl;
    wire  [7:0] ivl_eff = (ivl == 8'h00) ? 8'h01 : ivl;
    wire        due     = tick && ((sec_cnt + 8'h01) >= ivl_eff);
    wire  [8:0] up_sum  = {2'b00, duty} + {1'b0, up_step};
    wire  [8:0] dn_diff = {2'b00, duty} - {1'b0, down_step};
    wire  [6:0] raised  = (up_sum > {2'b00, ceil_duty}) ? ceil_duty : up_sum[6:0];
    wire  [6:0] lowered = (dn_diff[8] || (dn_diff < {2'b00, floor_duty}))
                          ? floor_duty : dn_diff[6:0];

    always_comb
    begin
        next_sec_cnt = sec_cnt;
        next_duty    = duty;
        if (!(hot || cold))
        begin
            next_sec_cnt = 8'h00;
        end
        else if (due)
        begin
            next_sec_cnt = 8'h00;
            next_duty    = hot ? raised : lowered;
        end
        else if (tick)
        begin
            next_sec_cnt = sec_cnt + 8'h01;
        end
        // Settings may move under a running duty, so it is pulled back into range.
        if (next_duty > ceil_duty)
        begin
            next_duty = ceil_duty;
        end
        if (next_duty < floor_duty)
        begin
            next_duty = floor_duty;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sec_cnt <= 8'h00;
            duty    <= RST_FLOOR;
        end
        else
        begin
            sec_cnt <= next_sec_cnt;
            duty    <= next_duty;
        end
    end
endmodule : fzdc_zone

// File: verilog/fzdc_top.sv
// Fan zone duty controller: APB registers, sensor sampling, three zones, fan drive.
// Assumes sensor and failure pins are asynchronous and readings are degrees C.
`timescale 1ns/1ns
module fzdc_top
    import fzdc_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Temperature sensors.
    input  wire logic [7:0]  processor_a_temp,
    input  wire logic        processor_a_valid,
    input  wire logic [7:0]  processor_b_temp,
    input  wire logic        processor_b_valid,
    input  wire logic [7:0]  graphics_temp_sensor,
    input  wire logic        graphics_temp_valid,
    input  wire logic [7:0]  storage_temp_sensor,
    input  wire logic        storage_temp_valid,
    input  wire logic [7:0]  ambient_temp_sensor,
    input  wire logic        ambient_temp_valid,
    // Fault and update indications.
    input  wire logic [4:0]  fan_fail,
    input  wire logic        fw_update,
    // Fan duty drive in percent.
    output logic      [6:0]  cpu_zone_fan_a,
    output logic      [6:0]  cpu_zone_fan_b,
    output logic      [6:0]  expansion_zone_fan_a,
    output logic      [6:0]  expansion_zone_fan_b,
    output logic      [6:0]  supply_storage_zone_fan
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers.

    localparam int SYNC_W = 5 * 9 + NUM_FANS + 1;

    logic [SYNC_W-1:0] sync_meta;
    logic [SYNC_W-1:0] sync_q;

    wire [SYNC_W-1:0] sync_raw =
        {fw_update, fan_fail,
         ambient_temp_valid, ambient_temp_sensor,
         storage_temp_valid, storage_temp_sensor,
         graphics_temp_valid, graphics_temp_sensor,
         processor_b_valid, processor_b_temp,
         processor_a_valid, processor_a_temp};

    // Readings are slow-moving levels; a torn byte settles within one cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_meta <= '0;
            sync_q    <= '0;
        end
        else
        begin
            sync_meta <= sync_raw;
            sync_q    <= sync_meta;
        end
    end

    wire [4:0] fail_s  = sync_q[49:45];
    wire       upd_s   = sync_q[50];

    ////////////////////////////////////////////////////////////////////////
    // Reading qualification.

    // The bits of a reading cross one by one, so a changing byte can show a
    // torn value for a cycle. A reading is taken only once two samples agree,
    // which delays every temperature change by two more cycles.
    localparam int NUM_SENSORS = 5;

    logic [8:0] rd_prev [NUM_SENSORS];
    logic [8:0] rd_held [NUM_SENSORS];
    wire  [8:0] rd_sync [NUM_SENSORS];

    assign rd_sync[0] = sync_q[8:0];
    assign rd_sync[1] = sync_q[17:9];
    assign rd_sync[2] = sync_q[26:18];
    assign rd_sync[3] = sync_q[35:27];
    assign rd_sync[4] = sync_q[44:36];

    genvar gs;
    generate
        for (gs = 0; gs < NUM_SENSORS; gs++)
        begin : g_sensor
            // Valid is also seen twice but needs no steady byte, so it can rise a cycle ahead of a torn byte.
            wire       steady = (rd_sync[gs] == rd_prev[gs]);
            wire       keep_v = rd_sync[gs][8] && rd_prev[gs][8];
            wire [7:0] keep_t = steady ? rd_sync[gs][7:0] : rd_held[gs][7:0];

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    rd_prev[gs] <= 9'h000;
                    rd_held[gs] <= 9'h000;
                end
                else
                begin
                    rd_prev[gs] <= rd_sync[gs];
                    rd_held[gs] <= {keep_v, keep_t};
                end
            end
        end
    endgenerate

    wire [7:0] pa_t    = rd_held[0][7:0];
    wire       pa_v    = rd_held[0][8];
    wire [7:0] pb_t    = rd_held[1][7:0];
    wire       pb_v    = rd_held[1][8];
    wire [7:0] gr_t    = rd_held[2][7:0];
    wire       gr_v    = rd_held[2][8];
    wire [7:0] st_t    = rd_held[3][7:0];
    wire       st_v    = rd_held[3][8];
    wire [7:0] am_t    = rd_held[4][7:0];
    wire       am_v    = rd_held[4][8];

    ////////////////////////////////////////////////////////////////////////
    // Zone readings.

    wire       pa_use  = pa_v && (!pb_v || (pa_t >= pb_t));
    wire       gr_use  = gr_v && (!st_v || (gr_t >= st_t));

    wire [7:0] z_temp [NUM_ZONES];
    wire       z_valid[NUM_ZONES];

    assign z_temp[0]  = pa_use ? pa_t : pb_t;
    assign z_valid[0] = pa_v || pb_v;
    assign z_temp[1]  = gr_use ? gr_t : st_t;
    assign z_valid[1] = gr_v || st_v;
    assign z_temp[2]  = am_t;
    assign z_valid[2] = am_v;

    ////////////////////////////////////////////////////////////////////////
    // One-second tick.

    logic [31:0] tick_cnt;
    logic        tick;

    wire tick_wrap = (tick_cnt == 32'(TICK_CYCLES_P - 1));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_cnt <= 32'h0000_0000;
            tick     <= 1'b0;
        end
        else
        begin
            tick_cnt <= tick_wrap ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
            tick     <= tick_wrap;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file.

    logic [6:0]  floor_duty;
    logic [6:0]  ceil_duty;
    logic        sw_force;
    logic [31:0] zone_a [NUM_ZONES];
    logic [31:0] zone_b [NUM_ZONES];
    logic [6:0]  duty   [NUM_ZONES];
    logic        forced;

    wire        setup    = psel && !penable;
    wire        wr_done  = psel && penable && pready && pwrite;
    wire        is_ctrl  = (paddr == OFS_CTRL);
    wire        is_stat  = (paddr == OFS_STATUS);
    wire        is_zone  = (paddr >= OFS_ZONE_BASE) && (paddr <= OFS_ZONE_END)
                           && (paddr[1:0] == 2'b00);
    wire [7:0]  zone_off = paddr - OFS_ZONE_BASE;
    wire [1:0]  zone_idx = zone_off[4:3];
    wire        zone_hi  = zone_off[2];
    wire        mapped   = is_ctrl || is_stat || is_zone;
    wire        bad_wr   = pwrite && is_stat;

    wire [31:0] ctrl_word =
        (32'(floor_duty) << POS_FLOOR) |
        (32'(ceil_duty) << POS_CEIL) |
        (32'(sw_force) << POS_FORCE);

    wire [31:0] stat_word =
        32'(duty[0]) |
        (32'(duty[1]) << 8) |
        (32'(duty[2]) << 16) |
        (32'(forced) << POS_ST_FORCED) |
        (32'(|fail_s) << POS_ST_FAIL) |
        (32'(upd_s) << POS_ST_UPDATE);

    wire [31:0] zone_word = zone_hi ? zone_b[zone_idx] : zone_a[zone_idx];

    wire [31:0] rd_word = is_ctrl ? ctrl_word :
                          is_stat ? stat_word :
                          is_zone ? zone_word : 32'h0000_0000;

    // No wait states: the answer is registered in the setup cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup && (!mapped || bad_wr);
            prdata  <= (setup && !pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            floor_duty <= RST_FLOOR;
            ceil_duty  <= RST_CEIL;
            sw_force   <= 1'b0;
        end
        else if (wr_done && is_ctrl)
        begin
            floor_duty <= pwdata[POS_FLOOR +: 7];
            ceil_duty  <= pwdata[POS_CEIL +: 7];
            sw_force   <= pwdata[POS_FORCE];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Zones.

    genvar gz;
    generate
        for (gz = 0; gz < NUM_ZONES; gz++)
        begin : g_zone
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    zone_a[gz] <= {8'h00, RST_HYST, RST_DOWN_TEMP[gz],
                                   RST_UP_TEMP[gz]};
                    zone_b[gz] <= {RST_STEP, RST_IVL, RST_STEP, RST_IVL};
                end
                else if (wr_done && is_zone && (zone_idx == 2'(gz)))
                begin
                    if (zone_hi)
                    begin
                        zone_b[gz] <= pwdata;
                    end
                    else
                    begin
                        zone_a[gz] <= {8'h00, pwdata[23:0]};
                    end
                end
            end

            fzdc_zone u_zone
            (
                .clk        (pclk),
                .rst_n      (presetn),
                .tick       (tick),
                .temp       (z_temp[gz]),
                .temp_valid (z_valid[gz]),
                .up_temp    (zone_a[gz][POS_UP_TEMP +: 8]),
                .down_temp  (zone_a[gz][POS_DOWN_TEMP +: 8]),
                .hyst       (zone_a[gz][POS_HYST +: 8]),
                .up_ivl     (zone_b[gz][POS_UP_IVL +: 8]),
                .up_step    (zone_b[gz][POS_UP_STEP +: 8]),
                .down_ivl   (zone_b[gz][POS_DOWN_IVL +: 8]),
                .down_step  (zone_b[gz][POS_DOWN_STEP +: 8]),
                .floor_duty (floor_duty),
                .ceil_duty  (ceil_duty),
                .duty       (duty[gz])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Fan drive.

    // The zones keep ramping while forced so the loop resumes smoothly after.
    wire next_forced = (|fail_s) || upd_s || sw_force;
    wire [6:0] z1_out = next_forced ? DUTY_FULL : duty[0];
    wire [6:0] z2_out = next_forced ? DUTY_FULL : duty[1];
    wire [6:0] z3_out = next_forced ? DUTY_FULL : duty[2];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            forced <= 1'b0;
        end
        else
        begin
            forced <= next_forced;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cpu_zone_fan_a          <= RST_FLOOR;
            cpu_zone_fan_b          <= RST_FLOOR;
            expansion_zone_fan_a    <= RST_FLOOR;
            expansion_zone_fan_b    <= RST_FLOOR;
            supply_storage_zone_fan <= RST_FLOOR;
        end
        else
        begin
            cpu_zone_fan_a          <= z1_out;
            cpu_zone_fan_b          <= z1_out;
            expansion_zone_fan_a    <= z2_out;
            expansion_zone_fan_b    <= z2_out;
            supply_storage_zone_fan <= z3_out;
        end
    end

endmodule : fzdc_top

// File: testbench/fzdc_top_asserts.sv
// Port-level checks of the fan zone duty controller, bound into its top module.
// Assumes floor and ceiling stay at their reset values throughout the run.
`timescale 1ns/1ns
module fzdc_top_asserts
    import fzdc_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
    // Clock, reset and bus.
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Update indication and fan drive.
    input wire logic        fw_update,
    input wire logic [6:0]  cpu_zone_fan_a,
    input wire logic [6:0]  cpu_zone_fan_b,
    input wire logic [6:0]  expansion_zone_fan_a,
    input wire logic [6:0]  expansion_zone_fan_b,
    input wire logic [6:0]  supply_storage_zone_fan
);
    logic [6:0] prev_fan;
    int         gap;
    logic       ramp_chg;
    // Jumps into and out of full speed are not ramp steps, so they leave the gap count alone.
    assign ramp_chg = supply_storage_zone_fan != prev_fan && prev_fan != DUTY_FULL
                      && supply_storage_zone_fan != DUTY_FULL;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev_fan <= RST_FLOOR;
            gap      <= TICK_CYCLES_P;
        end
        else
        begin
            prev_fan <= supply_storage_zone_fan;
            gap      <= ramp_chg ? 1 : (gap < TICK_CYCLES_P ? gap + 1 : gap);
        end
    end
    function automatic logic in_band(input logic [6:0] d);
        return (d >= RST_FLOOR && d <= RST_CEIL) || d == DUTY_FULL;
    endfunction : in_band
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_update_held;
        fw_update [*4];
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_pready_next:
        assert property (s_setup |=> pready) else $error("no answer after setup");
    a_pready_access:
        assert property (pready |-> psel && penable) else $error("pready outside access");
    a_prdata_idle:
        assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
    a_refuse_err:
        assert property (psel && !penable
            && (paddr > OFS_ZONE_END || (pwrite && paddr == OFS_STATUS))
            |=> pslverr && prdata == 32'h0) else $error("bad access not refused");
    a_cpu_pair:
        assert property (cpu_zone_fan_a == cpu_zone_fan_b) else $error("zone one fans differ");
    a_exp_pair:
        assert property (expansion_zone_fan_a == expansion_zone_fan_b)
        else $error("zone two fans differ");
    a_duty_band:
        assert property (in_band(cpu_zone_fan_a) && in_band(expansion_zone_fan_a)
            && in_band(supply_storage_zone_fan)) else $error("duty out of band");
    a_force_full:
        assert property (s_update_held |-> cpu_zone_fan_a == DUTY_FULL
            && expansion_zone_fan_a == DUTY_FULL && supply_storage_zone_fan == DUTY_FULL)
        else $error("update did not force full speed");
    a_ramp_spacing:
        assert property (ramp_chg |-> gap >= TICK_CYCLES_P) else $error("ramp steps too close");
endmodule : fzdc_top_asserts

bind fzdc_top fzdc_top_asserts #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_asserts (.*);

// File: testbench/fzdc_sensor_model.sv
// Behavioural temperature sensors and fan fault lines facing the controller.
// Assumes the bench sets readings by task; every output moves on a rising edge.
`timescale 1ns/1ns
module fzdc_sensor_model
(
    // Clock.
    input  wire logic       pclk,
    // Readings and valid flags.
    output logic      [7:0] processor_a_temp,
    output logic      [7:0] processor_b_temp,
    output logic      [7:0] graphics_temp_sensor,
    output logic      [7:0] storage_temp_sensor,
    output logic      [7:0] ambient_temp_sensor,
    output logic            processor_a_valid,
    output logic            processor_b_valid,
    output logic            graphics_temp_valid,
    output logic            storage_temp_valid,
    output logic            ambient_temp_valid,
    // Fan faults.
    output logic      [4:0] fan_fail
);
    logic [7:0] t [5] = '{default: 8'h00};
    logic [7:0] q [5] = '{default: 8'h00};
    logic [4:0] v     = 5'h00;
    logic [4:0] vq    = 5'h00;
    logic [4:0] fail  = 5'h00;
    logic [4:0] fq    = 5'h00;
    task set(input int i, input logic [7:0] val, input logic ok);
        t[i] = val;
        v[i] = ok;
    endtask : set
    // An invalid sensor keeps toggling, so a reading used without its flag shows up.
    always @(posedge pclk)
    begin
        for (int i = 0; i < 5; i++)
            q[i] <= v[i] ? t[i] : ~q[i];
        vq <= v;
        fq <= fail;
    end
    assign processor_a_temp     = q[0];
    assign processor_b_temp     = q[1];
    assign graphics_temp_sensor = q[2];
    assign storage_temp_sensor  = q[3];
    assign ambient_temp_sensor  = q[4];
    assign {ambient_temp_valid, storage_temp_valid, graphics_temp_valid, processor_b_valid,
            processor_a_valid} = vq;
    assign fan_fail = fq;
endmodule : fzdc_sensor_model

// File: testbench/tb_fan_zone_duty_controller.sv
// Self-checking bench: register map, zone ramps, clamping and forced full speed.
// Assumes a one-second tick shortened to T cycles and the sensor model beside the design.
`timescale 1ns/1ns
module tb_fan_zone_duty_controller;
    import fzdc_pkg::*;
    localparam int          T   = 20;
    localparam logic [7:0]  ADR [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
    localparam logic [31:0] RSV [8] = '{32'h00005F0F, 32'h000F0F0F, 32'h00004150, 32'h01010101,
                                        32'h00003C46, 32'h01010101, 32'h0000323C, 32'h01010101};
    logic        pclk = 1'b0, presetn = 1'b0, fw_update = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er;
    logic [7:0]  processor_a_temp, processor_b_temp, graphics_temp_sensor, storage_temp_sensor;
    logic [7:0]  ambient_temp_sensor;
    logic        processor_a_valid, processor_b_valid, graphics_temp_valid, storage_temp_valid;
    logic        ambient_temp_valid;
    logic [4:0]  fan_fail;
    logic [6:0]  cpu_zone_fan_a, cpu_zone_fan_b, expansion_zone_fan_a, expansion_zone_fan_b;
    logic [6:0]  supply_storage_zone_fan;
    logic [6:0]  z1;
    int          fails = 0, num_checks = 0, cycles = 0;
    fzdc_top #(.TICK_CYCLES_P(T)) dut (.*);
    fzdc_sensor_model sens (.*);
    always #10 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////////////////////
    task results;
        if (fails == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results
    // The run is under two thousand cycles; a hang is cut well beyond that.
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            results();
        end
    end
    task chk32(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %0t word %h expected %h", $time, got, exp);
        end
    endtask : chk32
    task chk7(input logic [6:0] got, input logic [6:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %0t duty %h expected %h", $time, got, exp);
        end
    endtask : chk7
    function automatic logic [6:0] fan(input int f);
        case (f)
            0: return cpu_zone_fan_a;
            1: return cpu_zone_fan_b;
            2: return expansion_zone_fan_a;
            3: return expansion_zone_fan_b;
            default: return supply_storage_zone_fan;
        endcase
    endfunction : fan
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    // Waits for the first step of the new direction, then n steps of d, clamped to the band.
    task ramp(input int f, input int d, input int n);
        logic [6:0] v;
        int         k;
        int         e;
        k = 0;
        repeat (8) @(posedge pclk);
        v = fan(f);
        while (d != 0 && fan(f) === v && k < 100)
        begin
            @(posedge pclk);
            k++;
        end
        v = fan(f);
        repeat (n * T + 2) @(posedge pclk);
        e = int'(v) + d * n;
        e = e > int'(RST_CEIL) ? int'(RST_CEIL) : (e < int'(RST_FLOOR) ? int'(RST_FLOOR) : e);
        chk7(fan(f), 7'(e));
    endtask : ramp
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 5; i++) chk7(fan(i), RST_FLOOR);
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b0, ADR[i], 32'h0);
            chk32(rd, RSV[i]);
            chk32({31'h0, er}, 32'h0);
        end
        apb(1'b0, 8'h20, 32'h0);
        chk32({rd[30:0], er}, 32'h1);
        apb(1'b1, OFS_STATUS, 32'hFFFFFFFF);
        chk32({31'h0, er}, 32'h1);
        sens.set(0, 8'h55, 1'b1);
        sens.set(1, 8'hC8, 1'b0);
        sens.set(2, 8'h41, 1'b1);
        sens.set(4, 8'h28, 1'b1);
        ramp(0, 1, 3);
        ramp(2, 0, 2);
        ramp(4, 0, 1);
        sens.set(0, 8'h40, 1'b1);
        ramp(1, -1, 2);
        sens.set(0, 8'h41, 1'b1);
        ramp(0, 0, 2);
        z1 = fan(0);
        sens.set(2, 8'h46, 1'b1);
        ramp(2, 1, 2);
        sens.set(2, 8'h1E, 1'b1);
        sens.set(3, 8'h4B, 1'b1);
        ramp(3, 1, 1);
        sens.set(3, 8'h3B, 1'b1);
        ramp(3, -1, 1);
        apb(1'b1, 8'h1C, 32'h01010A01);
        sens.set(4, 8'h3C, 1'b1);
        ramp(4, 10, 9);
        sens.set(4, 8'h31, 1'b1);
        ramp(4, -1, 2);
        fw_update <= 1'b1;
        repeat (5) @(posedge pclk);
        for (int i = 0; i < 5; i++) chk7(fan(i), DUTY_FULL);
        fw_update <= 1'b0;
        for (int b = 0; b < 5; b++)
        begin
            sens.fail <= 5'h01 << b;
            repeat (6) @(posedge pclk);
            for (int i = 0; i < 5; i++) chk7(fan(i), DUTY_FULL);
        end
        sens.fail <= 5'h00;
        apb(1'b1, OFS_CTRL, 32'h00015F0F);
        repeat (2) @(posedge pclk);
        for (int i = 0; i < 5; i++) chk7(fan(i), DUTY_FULL);
        apb(1'b1, OFS_CTRL, 32'h00005F0F);
        repeat (2) @(posedge pclk);
        chk7(fan(0), z1);
        chk7(fan(1), z1);
        results();
    end
endmodule : tb_fan_zone_duty_controller
